// ---- src/pe_regs.vh ----
// Register offsets, field positions, reset values and timing counts of the pin event block.
`ifndef PE_REGS_VH
`define PE_REGS_VH

`define PE_ADDR_W 12
`define PE_PIN_N 6

`define PE_OFF_INDICATOR_CFG 12'h1BC
`define PE_OFF_PIN_CFG 12'h1E0
`define PE_OFF_PIN_DATA_DIR 12'h1E4
`define PE_OFF_PIN_SYSTEM_INTERRUPT_STATUS_EN 12'h1E8

`define PE_STS_LSB 0
`define PE_STS_MSB 5
`define PE_EN_LSB 16
`define PE_EN_MSB 21
`define PE_DRV_LSB 0
`define PE_DRV_MSB 5
`define PE_POL_LSB 16
`define PE_POL_MSB 21
`define PE_DATA_LSB 0
`define PE_DATA_MSB 5
`define PE_DIR_LSB 16
`define PE_DIR_MSB 21
`define PE_SEL_LSB 0
`define PE_SEL_MSB 5
`define PE_FUN_LSB 8
`define PE_FUN_MSB 9

`define PE_FUN_PUSH_PULL 2'h3
`define PE_PINS_RESET 6'h00

`define PE_CLK_PERIOD_NS 20
`define PE_MIN_ACTIVE_NS 40
`define PE_MIN_ACTIVE_CYC ((`PE_MIN_ACTIVE_NS + `PE_CLK_PERIOD_NS - 1) / `PE_CLK_PERIOD_NS)

`endif

// ---- src/pe_pin_filter.v ----
// Two-stage synchroniser and minimum-width level filter for one pin input.
`timescale 1ns/100ps
`include "pe_regs.vh"

module pe_pin_filter #(
  parameter MIN_CYC = `PE_MIN_ACTIVE_CYC,
  parameter CNT_W = 4
) (
  input wire clk_sys_i,
  input wire reset_n_i,
  input wire pin_raw_i,
  output reg pin_level_o
);

  reg sync_a;
  reg sync_b;
  reg [CNT_W-1:0] stable_cnt;
  reg [CNT_W-1:0] next_stable_cnt;
  reg next_level;

  // A new level is accepted only after it has been seen on MIN_CYC consecutive edges,
  // so a glitch that spans fewer than MIN_CYC sampling edges never reaches the status bits.
  always @* begin
    next_stable_cnt = {CNT_W{1'b0}};
    next_level = pin_level_o;
    if (sync_b != pin_level_o) begin
      if (stable_cnt == MIN_CYC[CNT_W-1:0] - 1'b1) begin
        next_level = sync_b;
      end else begin
        next_stable_cnt = stable_cnt + 1'b1;
      end
    end
  end

  always @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      // Reset to the pulled-up idle level, so a low-triggered pin sees no false event.
      sync_a <= 1'b1;
      sync_b <= 1'b1;
      stable_cnt <= {CNT_W{1'b0}};
      pin_level_o <= 1'b1;
    end else begin
      sync_a <= pin_raw_i;
      sync_b <= sync_a;
      stable_cnt <= next_stable_cnt;
      pin_level_o <= next_level;
    end
  end

endmodule

// ---- src/pe_pin_ctrl.v ----
// Pin event detection, indicator configuration and pin drive for six shared pins.
`timescale 1ns/100ps
`include "pe_regs.vh"

// Operation
// - Writing 1 clears a status bit.
// - OR of enabled status gives pin event.
// - Per-pin enables, reset to zero.
// - Status captures regardless of enable.
// - Interrupt output needs top-level event enable.
// - Level sensitive, held over 40 ns.
// - Function select: 0 general, 1 indicator.
// - Function field matters only in indicator mode.
// - Indicator mode disables pull-up, input buffer.
// - Function 11b push-pull, else open drive.
// - Strap high makes open indicator active low.
// - Polarity ignores later loader values.
// - General mode follows pin configuration registers.
// - Indicator defaults latched from straps at reset.
// - Loader may replace strap defaults.
// - Trigger polarity: 0 low, 1 high.
// - Open-drain pin drives low only on 0.

module pe_pin_ctrl #(
  parameter PIN_N = `PE_PIN_N,
  parameter MIN_CYC = `PE_MIN_ACTIVE_CYC
) (
  input wire clk_sys_i,
  input wire reset_n_i,
  input wire [`PE_ADDR_W-1:0] reg_addr_i,
  input wire reg_wr_i,
  input wire reg_rd_i,
  input wire [31:0] reg_wdata_i,
  output reg [31:0] reg_rdata_o,
  input wire pin_event_enable_i,
  output wire pin_event_o,
  output wire irq_o,
  input wire [1:0] indicator_function_strap_i,
  input wire [5:0] indicator_select_strap_i,
  input wire [5:0] indicator_polarity_strap_i,
  input wire loader_wr_i,
  input wire [1:0] loader_function_i,
  input wire [5:0] loader_select_i,
  input wire [5:0] indicator_on_i,
  input wire [5:0] pin_in_i,
  output reg [5:0] pin_out_o,
  output reg [5:0] pin_oe_o,
  output wire [5:0] pin_pullup_en_o,
  output wire [5:0] pin_inbuf_en_o
);

  function hit;
    input [`PE_ADDR_W-1:0] addr;
    input [`PE_ADDR_W-1:0] off;
    begin
      hit = (addr == off);
    end
  endfunction

  reg [5:0] int_status;
  reg [5:0] int_enable;
  reg [5:0] pin_driver_type;
  reg [5:0] pin_trigger_polarity;
  reg [5:0] pin_data_bits;
  reg [5:0] pin_direction_bits;
  reg [1:0] indicator_function_field;
  reg [5:0] indicator_function_select;
  reg [5:0] indicator_active_low;
  reg strap_taken;
  reg [5:0] next_int_status;
  reg [31:0] next_rdata;
  wire [5:0] pin_level;
  wire [5:0] trigger;
  wire wr_sts;
  wire wr_cfg;
  wire wr_dd;
  wire wr_ind;
  wire push_pull_ind;

  assign wr_sts = reg_wr_i && hit(reg_addr_i, `PE_OFF_PIN_SYSTEM_INTERRUPT_STATUS_EN);
  assign wr_cfg = reg_wr_i && hit(reg_addr_i, `PE_OFF_PIN_CFG);
  assign wr_dd = reg_wr_i && hit(reg_addr_i, `PE_OFF_PIN_DATA_DIR);
  assign wr_ind = reg_wr_i && hit(reg_addr_i, `PE_OFF_INDICATOR_CFG);

  genvar g;
  generate
    for (g = 0; g < PIN_N; g = g + 1) begin : g_pin
      pe_pin_filter #(
        .MIN_CYC(MIN_CYC),
        .CNT_W(4)
      ) u_filter (
        .clk_sys_i(clk_sys_i),
        .reset_n_i(reset_n_i),
        .pin_raw_i(pin_in_i[g]),
        .pin_level_o(pin_level[g])
      );
    end
  endgenerate

  // Pins used as indicators have their input buffer off, so they cannot raise events.
  assign trigger = ~(pin_level ^ pin_trigger_polarity) & ~indicator_function_select;

  // The condition is level sensitive: a held level sets the bit again every cycle,
  // and the set wins over a clear written in the same cycle.
  always @* begin
    next_int_status = int_status;
    if (wr_sts) begin
      next_int_status = int_status & ~reg_wdata_i[`PE_STS_MSB:`PE_STS_LSB];
    end
    next_int_status = next_int_status | trigger;
  end

  assign pin_event_o = |(int_status & int_enable);
  assign irq_o = pin_event_o & pin_event_enable_i;

  always @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      int_status <= `PE_PINS_RESET;
      int_enable <= `PE_PINS_RESET;
    end else begin
      int_status <= next_int_status;
      if (wr_sts) begin
        int_enable <= reg_wdata_i[`PE_EN_MSB:`PE_EN_LSB];
      end
    end
  end

  always @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      pin_driver_type <= `PE_PINS_RESET;
      pin_trigger_polarity <= `PE_PINS_RESET;
      pin_data_bits <= `PE_PINS_RESET;
      pin_direction_bits <= `PE_PINS_RESET;
    end else begin
      if (wr_cfg) begin
        pin_driver_type <= reg_wdata_i[`PE_DRV_MSB:`PE_DRV_LSB];
        pin_trigger_polarity <= reg_wdata_i[`PE_POL_MSB:`PE_POL_LSB];
      end
      if (wr_dd) begin
        pin_data_bits <= reg_wdata_i[`PE_DATA_MSB:`PE_DATA_LSB];
        pin_direction_bits <= reg_wdata_i[`PE_DIR_MSB:`PE_DIR_LSB];
      end
    end
  end

  // Straps are caught on the first edge after reset release, since an asynchronous
  // reset may only load constants. Indicator configuration and loader writes in that first cycle are lost.
  always @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      strap_taken <= 1'b0;
      indicator_function_field <= 2'h0;
      indicator_function_select <= `PE_PINS_RESET;
      indicator_active_low <= `PE_PINS_RESET;
    end else if (!strap_taken) begin
      strap_taken <= 1'b1;
      indicator_function_field <= indicator_function_strap_i;
      indicator_function_select <= indicator_select_strap_i;
      indicator_active_low <= indicator_polarity_strap_i;
    end else if (loader_wr_i) begin
      indicator_function_field <= loader_function_i;
      indicator_function_select <= loader_select_i;
    end else if (wr_ind) begin
      indicator_function_field <= reg_wdata_i[`PE_FUN_MSB:`PE_FUN_LSB];
      indicator_function_select <= reg_wdata_i[`PE_SEL_MSB:`PE_SEL_LSB];
    end
  end

  // The polarity register is loaded only at strap time; the loader never touches it.

  assign push_pull_ind = (indicator_function_field == `PE_FUN_PUSH_PULL);
  assign pin_pullup_en_o = ~indicator_function_select;
  assign pin_inbuf_en_o = ~indicator_function_select;

  integer i;
  always @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      pin_out_o <= `PE_PINS_RESET;
      pin_oe_o <= `PE_PINS_RESET;
    end else begin
      for (i = 0; i < PIN_N; i = i + 1) begin
        if (indicator_function_select[i]) begin
          if (push_pull_ind) begin
            pin_out_o[i] <= indicator_on_i[i];
            pin_oe_o[i] <= 1'b1;
          end else begin
            // Active low drives 0 when lit; active high drives 1 when lit.
            pin_out_o[i] <= ~indicator_active_low[i];
            pin_oe_o[i] <= indicator_on_i[i];
          end
        end else if (pin_direction_bits[i]) begin
          if (pin_driver_type[i]) begin
            pin_out_o[i] <= pin_data_bits[i];
            pin_oe_o[i] <= 1'b1;
          end else begin
            pin_out_o[i] <= 1'b0;
            pin_oe_o[i] <= ~pin_data_bits[i];
          end
        end else begin
          pin_out_o[i] <= 1'b0;
          pin_oe_o[i] <= 1'b0;
        end
      end
    end
  end

  always @* begin
    next_rdata = 32'h00000000;
    if (hit(reg_addr_i, `PE_OFF_PIN_SYSTEM_INTERRUPT_STATUS_EN)) begin
      next_rdata[`PE_STS_MSB:`PE_STS_LSB] = int_status;
      next_rdata[`PE_EN_MSB:`PE_EN_LSB] = int_enable;
    end else if (hit(reg_addr_i, `PE_OFF_PIN_CFG)) begin
      next_rdata[`PE_DRV_MSB:`PE_DRV_LSB] = pin_driver_type;
      next_rdata[`PE_POL_MSB:`PE_POL_LSB] = pin_trigger_polarity;
    end else if (hit(reg_addr_i, `PE_OFF_PIN_DATA_DIR)) begin
      // Inputs read the filtered pin, outputs the last written value.
      next_rdata[`PE_DATA_MSB:`PE_DATA_LSB] =
        (pin_data_bits & pin_direction_bits) | (pin_level & ~pin_direction_bits);
      next_rdata[`PE_DIR_MSB:`PE_DIR_LSB] = pin_direction_bits;
    end else if (hit(reg_addr_i, `PE_OFF_INDICATOR_CFG)) begin
      next_rdata[`PE_FUN_MSB:`PE_FUN_LSB] = indicator_function_field;
      next_rdata[`PE_SEL_MSB:`PE_SEL_LSB] = indicator_function_select;
    end
  end

  always @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      reg_rdata_o <= 32'h00000000;
    end else if (reg_rd_i) begin
      reg_rdata_o <= next_rdata;
    end
  end

endmodule

// ---- tb/pe_pin_ctrl_assertions.sv ----
// Port-level checker of the pin event block and its bind.
`timescale 1ns/100ps
`include "pe_regs.vh"
module pe_ctrl_chk (
  input wire clk_sys_i,
  input wire reset_n_i,
  input wire [`PE_ADDR_W-1:0] reg_addr_i,
  input wire reg_wr_i,
  input wire reg_rd_i,
  input wire [31:0] reg_wdata_i,
  input wire [31:0] reg_rdata_o,
  input wire pin_event_enable_i,
  input wire pin_event_o,
  input wire irq_o,
  input wire [5:0] indicator_polarity_strap_i,
  input wire loader_wr_i,
  input wire [5:0] indicator_on_i,
  input wire [5:0] pin_out_o,
  input wire [5:0] pin_oe_o,
  input wire [5:0] pin_pullup_en_o,
  input wire [5:0] pin_inbuf_en_o
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!reset_n_i);
  wire quiet = !reg_wr_i && !loader_wr_i;
  wire [5:0] sel = reg_rdata_o[5:0];
  wire pp = reg_rdata_o[9:8] == `PE_FUN_PUSH_PULL;
  // The drive lags the configuration by one edge, so the check waits one quiet cycle.
  sequence s_cfg;
    reg_rd_i && reg_addr_i == `PE_OFF_INDICATOR_CFG && quiet ##1 quiet && !reg_rd_i;
  endsequence
  a_irq_gate: assert property (irq_o == (pin_event_o && pin_event_enable_i))
    else $error("irq differs from gated event");
  a_event_or: assert property (reg_rd_i && reg_addr_i == `PE_OFF_PIN_SYSTEM_INTERRUPT_STATUS_EN |=>
    $past(pin_event_o) == |(reg_rdata_o[5:0] & reg_rdata_o[21:16]))
    else $error("event differs from enabled status");
  a_buf_off: assert property (reg_rd_i && reg_addr_i == `PE_OFF_INDICATOR_CFG && quiet |=>
    pin_pullup_en_o == ~sel) else $error("pull-up on for indicator pin");
  a_buf_pair: assert property (pin_inbuf_en_o == pin_pullup_en_o)
    else $error("input buffer differs from pull-up");
  a_en_write: assert property (reg_wr_i && reg_addr_i == `PE_OFF_PIN_SYSTEM_INTERRUPT_STATUS_EN &&
    reg_wdata_i[21:16] == 6'h00 |=> !pin_event_o) else $error("event with enables off");
  a_en_reset: assert property ($rose(reset_n_i) |-> !pin_event_o)
    else $error("event right after reset");
  a_pp_drive: assert property (s_cfg |=> !pp || ((pin_oe_o & sel) == sel &&
    ((pin_out_o ^ $past(indicator_on_i)) & sel) == 6'h00)) else $error("push-pull drive wrong");
  a_open_pol: assert property (s_cfg |=> pp || ((pin_oe_o & sel) ==
    ($past(indicator_on_i) & sel) && (pin_out_o & sel) == (~indicator_polarity_strap_i & sel)))
    else $error("open indicator drive wrong");
  a_rdata_hold: assert property (!reg_rd_i |=> $stable(reg_rdata_o))
    else $error("read data moved without read");
  c_irq: cover property (irq_o);
  c_pp: cover property (s_cfg ##1 pp);
  c_load: cover property (loader_wr_i);
endmodule

bind pe_pin_ctrl pe_ctrl_chk chk_u (.clk_sys_i, .reset_n_i, .reg_addr_i, .reg_wr_i, .reg_rd_i,
  .reg_wdata_i, .reg_rdata_o, .pin_event_enable_i, .pin_event_o, .irq_o, .loader_wr_i,
  .indicator_polarity_strap_i, .indicator_on_i, .pin_out_o, .pin_oe_o, .pin_pullup_en_o,
  .pin_inbuf_en_o);

// ---- tb/pe_pin_model.sv ----
// Behavioural model of the outside world on the six shared pins.
`timescale 1ns/100ps
module pe_pin_model (
  input wire clk_sys_i,
  input wire [5:0] out_i,
  input wire [5:0] oe_i,
  input wire [5:0] pu_i,
  input wire [5:0] src_val_i,
  input wire [5:0] src_drv_i,
  output wire [5:0] pin_o
);
  reg [5:0] last = 6'h00;
  // A floating line without pull-up flips every cycle so a stale level cannot pass.
  always @(posedge clk_sys_i) begin
    last <= ~pin_o;
  end
  assign pin_o = (oe_i & out_i) | (~oe_i & src_drv_i & src_val_i) |
    (~oe_i & ~src_drv_i & (pu_i | last));
endmodule

// ---- tb/pin_event_and_indicator_control_test.sv ----
// Self-checking bench of the pin event and indicator block.
`timescale 1ns/100ps
`include "pe_regs.vh"
module pin_event_and_indicator_control_test;
  localparam [11:0] sts = `PE_OFF_PIN_SYSTEM_INTERRUPT_STATUS_EN;
  localparam [11:0] ind = `PE_OFF_INDICATOR_CFG;
  reg clk_sys_i = 1'b0;
  reg reset_n_i = 1'b0;
  reg [11:0] reg_addr_i = 12'h000;
  reg reg_wr_i = 1'b0;
  reg reg_rd_i = 1'b0;
  reg [31:0] reg_wdata_i = 32'h0;
  reg pin_event_enable_i = 1'b0;
  reg [1:0] indicator_function_strap_i = 2'h1;
  reg [5:0] indicator_select_strap_i = 6'h30;
  reg [5:0] indicator_polarity_strap_i = 6'h10;
  reg loader_wr_i = 1'b0;
  reg [1:0] loader_function_i = 2'h0;
  reg [5:0] loader_select_i = 6'h01;
  reg [5:0] indicator_on_i = 6'h30;
  reg [5:0] src_val = 6'h02;
  reg [5:0] src_drv = 6'h03;
  wire [31:0] reg_rdata_o;
  wire pin_event_o;
  wire irq_o;
  wire [5:0] pin_in_i, pin_out_o, pin_oe_o, pin_pullup_en_o, pin_inbuf_en_o;
  integer fails = 0;
  integer compares = 0;
  integer cycles = 0;
  always #10 clk_sys_i = ~clk_sys_i;
  pe_pin_ctrl #(.MIN_CYC(2)) dut_u (.clk_sys_i, .reset_n_i, .reg_addr_i, .reg_wr_i,
    .reg_rd_i, .reg_wdata_i, .reg_rdata_o, .pin_event_enable_i, .pin_event_o, .irq_o,
    .indicator_function_strap_i, .indicator_select_strap_i, .indicator_polarity_strap_i,
    .loader_wr_i, .loader_function_i, .loader_select_i, .indicator_on_i, .pin_in_i,
    .pin_out_o, .pin_oe_o, .pin_pullup_en_o, .pin_inbuf_en_o);
  pe_pin_model model_u (.clk_sys_i, .out_i(pin_out_o), .oe_i(pin_oe_o),
    .pu_i(pin_pullup_en_o), .src_val_i(src_val), .src_drv_i(src_drv), .pin_o(pin_in_i));
  task test_done;
    begin
      $display("compares %0d fails %0d", compares, fails);
      if (fails == 0 && compares > 0)
        $display("*** PASS ***");
      else
        $display("*** FAIL ***");
      $finish;
    end
  endtask
  task chk(input string nm, input [31:0] e, input [31:0] g);
    begin
      compares = compares + 1;
      if (g !== e) begin
        fails = fails + 1;
        $display("Error %0s expected %h seen %h", nm, e, g);
      end
    end
  endtask
  task tick(input integer n);
    begin
      repeat (n) @(posedge clk_sys_i);
      #1;
    end
  endtask
  task wr(input [11:0] a, input [31:0] d);
    begin
      @(posedge clk_sys_i);
      reg_addr_i <= a;
      reg_wdata_i <= d;
      reg_wr_i <= 1'b1;
      @(posedge clk_sys_i);
      reg_wr_i <= 1'b0;
    end
  endtask
  task rd(input [11:0] a, input [31:0] e);
    begin
      @(posedge clk_sys_i);
      reg_addr_i <= a;
      reg_rd_i <= 1'b1;
      @(posedge clk_sys_i);
      reg_rd_i <= 1'b0;
      #1;
      chk("rdata", e, reg_rdata_o);
    end
  endtask
  always @(posedge clk_sys_i) begin
    cycles <= cycles + 1;
    if (cycles == 2000) begin
      fails = fails + 1;
      test_done;
    end
  end
  initial begin
    repeat (10) @(posedge clk_sys_i);
    reset_n_i <= 1'b1;
    tick(2);
    rd(sts, 32'h0);
    rd(ind, 32'h130);
    rd(12'h000, 32'h0);
    wr(`PE_OFF_PIN_CFG, 32'h10000);
    rd(`PE_OFF_PIN_CFG, 32'h10000);
    // Pin 0 idles low, so it latched a low-level event before its polarity was turned.
    wr(sts, 32'h3F);
    @(posedge clk_sys_i) src_val <= 6'h03;
    @(posedge clk_sys_i) src_val <= 6'h02;
    tick(8);
    rd(sts, 32'h0);
    @(posedge clk_sys_i) src_val <= 6'h01;
    tick(4);
    @(posedge clk_sys_i) src_val <= 6'h02;
    tick(8);
    rd(sts, 32'h3);
    chk("event", 32'(pin_event_o), 32'h0);
    wr(sts, 32'h30000);
    rd(sts, 32'h30003);
    chk("event", 32'(pin_event_o), 32'h1);
    chk("irq", 32'(irq_o), 32'h0);
    @(posedge clk_sys_i) pin_event_enable_i <= 1'b1;
    tick(1);
    chk("irq", 32'(irq_o), 32'h1);
    wr(sts, 32'h30001);
    rd(sts, 32'h30002);
    wr(sts, 32'h10002);
    rd(sts, 32'h10000);
    chk("event", 32'(pin_event_o), 32'h0);
    @(posedge clk_sys_i) src_val <= 6'h03;
    tick(8);
    wr(sts, 32'h10001);
    rd(sts, 32'h10001);
    @(posedge clk_sys_i) src_val <= 6'h02;
    tick(8);
    wr(sts, 32'h10001);
    rd(sts, 32'h10000);
    chk("oe", 32'(pin_oe_o), 32'h30);
    chk("out", 32'(pin_out_o & 6'h30), 32'h20);
    chk("pullup", 32'(pin_pullup_en_o), 32'h0F);
    @(posedge clk_sys_i) indicator_on_i <= 6'h10;
    wr(ind, 32'h330);
    rd(ind, 32'h330);
    tick(2);
    chk("out", 32'(pin_out_o & 6'h30), 32'h10);
    wr(`PE_OFF_PIN_CFG, 32'h10004);
    wr(`PE_OFF_PIN_DATA_DIR, 32'hC0004);
    tick(2);
    chk("oe", 32'(pin_oe_o), 32'h3C);
    chk("out", 32'(pin_out_o & 6'h3C), 32'h14);
    wr(`PE_OFF_PIN_DATA_DIR, 32'hC000C);
    tick(2);
    chk("oe", 32'(pin_oe_o), 32'h34);
    @(posedge clk_sys_i) loader_wr_i <= 1'b1;
    @(posedge clk_sys_i) loader_wr_i <= 1'b0;
    tick(2);
    rd(ind, 32'h001);
    chk("pullup", 32'(pin_pullup_en_o), 32'h3E);
    test_done;
  end
endmodule
